// file: rtl/lowside_switch_pkg.sv
// Constants shared by the low-side switch serial control logic.
package lowside_switch_pkg;
    localparam int          CHANNELS        = 8;
    localparam int          SERIAL_CHANNELS = 6;
    localparam int          FRAME_BITS      = 8;
    localparam logic [2:0]  BIT_COUNT_LAST  = 3'h7;
    localparam logic [2:0]  BIT_COUNT_RESET = 3'h0;
    localparam logic [7:0]  SHIFT_RESET     = 8'h00;
    localparam logic [7:0]  COMMAND_RESET   = 8'h00;
    localparam logic [7:0]  STATUS_ALL_ONES = 8'hff;
    localparam logic [5:0]  SERIAL_MASK     = 6'h3f;
    localparam logic [1:0]  SYNC_RESET      = 2'h0;
    localparam logic [1:0]  SYNC_IDLE_HIGH  = 2'h3;
    localparam logic [7:0]  GATE_RESET      = 8'h00;
    localparam logic [28:0] PIN_SYNC_RESET  = 29'h0000000;
endpackage

// file: rtl/lowside_switch_serial_control.sv
// Serial command, status return and output gating of an eight-channel low-side switch.

// Notes on behaviour
// - Eight-bit frames, most significant bit first.
// - Command one is on; status one is fault.
// - Active gate drives switch output low.
// - Low parallel input is inactive; on channels 0 to 5 output high unless the channel's serial command bit is one.
// - Second byte of a frame echoes previous command bits.
// - Shift next status bit after falling clock.
// - Drive serial output once select falls, unless mode is high.
// - Release serial output after select rises.
// - Serial bit OR parallel pin on channels 0 to 5; parallel pin only on 6 and 7.
// - Mode high: pair pins drive channel pairs.
// - Over-voltage latches all outputs off.
// - Status most significant bit reports channel seven.
module lowside_switch_serial_control
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clockEnable,
    // Serial link pins.
    input  wire logic       serialClock,
    input  wire logic       chipSelect_n,
    input  wire logic       serialIn,
    output logic            serialOut,
    output logic            serialOutEnable,
    // Parallel and mode pins.
    input  wire logic [7:0] parallel_channel_inputs,
    input  wire logic       pair_input_ch0_ch1,
    input  wire logic       pair_input_ch2_ch3,
    input  wire logic       pair_input_ch4_ch5,
    input  wire logic       modeOverride,
    // Protection and sensing.
    input  wire logic       overVoltage,
    input  wire logic       overVoltageClear,
    input  wire logic [7:0] outputShorted,
    input  wire logic [7:0] outputOpenOrGround,
    // Gates, switch outputs and latched command.
    output logic [7:0]      gateDrive,
    output logic [7:0]      switch_outputs,
    output logic [7:0]      commandLatched
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read by logic.
    logic [1:0] sclkSync;
    logic [1:0] csSync;
    logic [1:0] siSync;
    logic [1:0] modeSync;
    logic       sclkLast;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclkSync <= lowside_switch_pkg::SYNC_RESET;
            csSync   <= lowside_switch_pkg::SYNC_IDLE_HIGH;
            siSync   <= lowside_switch_pkg::SYNC_RESET;
            modeSync <= lowside_switch_pkg::SYNC_RESET;
            sclkLast <= 1'b0;
        end
        else if (clockEnable)
        begin
            sclkSync <= {sclkSync[0], serialClock};
            csSync   <= {csSync[0], chipSelect_n};
            siSync   <= {siSync[0], serialIn};
            modeSync <= {modeSync[0], modeOverride};
            sclkLast <= sclkSync[1];
        end
    end

    // Level pins are synchronised too; two cycles are far below their own timing.
    logic [28:0] pinMeta;
    logic [28:0] pinSync;
    logic [7:0]  parallelSync;
    logic [2:0]  pairSync;
    logic        ovSync;
    logic        ovClearSync;
    logic [7:0]  shortedSync;
    logic [7:0]  openSync;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta <= lowside_switch_pkg::PIN_SYNC_RESET;
            pinSync <= lowside_switch_pkg::PIN_SYNC_RESET;
        end
        else if (clockEnable)
        begin
            pinMeta <= {outputOpenOrGround, outputShorted, overVoltageClear, overVoltage,
                        pair_input_ch4_ch5, pair_input_ch2_ch3, pair_input_ch0_ch1,
                        parallel_channel_inputs};
            pinSync <= pinMeta;
        end
    end
    assign {openSync, shortedSync, ovClearSync, ovSync, pairSync, parallelSync} = pinSync;

    logic sclkRise;
    logic sclkFall;
    logic selected;
    logic modeHigh;
    logic csLast;
    logic csRise;
    logic csFall;
    assign sclkRise = sclkSync[1] & ~sclkLast;
    assign sclkFall = ~sclkSync[1] & sclkLast;
    assign selected = ~csSync[1];
    assign modeHigh = modeSync[1];
    assign csRise   = csSync[1] & ~csLast;
    assign csFall   = ~csSync[1] & csLast;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            csLast <= 1'b1;
        else if (clockEnable)
            csLast <= csSync[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault capture and shift register.
    logic [7:0] faultStatus;
    logic [7:0] shiftReg;
    logic [7:0] echoReg;
    logic [7:0] commandReg;
    logic [2:0] bitCount;
    logic       echoPhase;

    always_comb
    begin
        for (int i = 0; i < lowside_switch_pkg::CHANNELS; i++)
            faultStatus[i] = gateDrive[i] ? shortedSync[i] : openSync[i];
    end

    // Serial output drives the most significant bit, so channel seven comes first.
    // MSB first shifting
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shiftReg  <= lowside_switch_pkg::SHIFT_RESET;
            echoReg   <= lowside_switch_pkg::SHIFT_RESET;
            bitCount  <= lowside_switch_pkg::BIT_COUNT_RESET;
            serialOut <= 1'b0;
            echoPhase <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (csFall)
            begin
                shiftReg  <= modeHigh ? lowside_switch_pkg::STATUS_ALL_ONES : faultStatus;
                serialOut <= modeHigh ? 1'b1 : faultStatus[7];
                echoReg   <= modeHigh ? lowside_switch_pkg::STATUS_ALL_ONES : commandReg;
                bitCount  <= lowside_switch_pkg::BIT_COUNT_RESET;
                echoPhase <= 1'b0;
            end
            else if (selected && sclkRise)
            begin
                shiftReg <= {shiftReg[6:0], siSync[1]};
            end
            else if (selected && sclkFall)
            begin
                bitCount <= bitCount + 3'h1;
                if (bitCount == lowside_switch_pkg::BIT_COUNT_LAST && !echoPhase)
                begin
                    // A second byte in the same frame returns the previous command.
                    echoPhase <= 1'b1;
                    serialOut <= echoReg[7];
                    echoReg   <= {echoReg[6:0], 1'b0};
                end
                else if (echoPhase)
                begin
                    serialOut <= echoReg[7];
                    echoReg   <= {echoReg[6:0], 1'b0};
                end
                else
                    serialOut <= shiftReg[7];
            end
        end
    end

    // mode also tri-states, pull-up reads ones
    assign serialOutEnable = selected & ~modeHigh;

    ////////////////////////////////////////////////////////////////////////////
    // Command latch on the rising edge of select; mode still reads the data.
    // latched command kept for echo
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            commandReg <= lowside_switch_pkg::COMMAND_RESET;
        else if (clockEnable && csRise)
            commandReg <= shiftReg;
    end
    assign commandLatched = commandReg;

    ////////////////////////////////////////////////////////////////////////////
    // Over-voltage latch; held until cleared, since the outputs must stay off.
    logic ovLatched;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ovLatched <= 1'b0;
        else if (clockEnable)
        begin
            if (ovSync)
                ovLatched <= 1'b1;
            else if (ovClearSync)
                ovLatched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate selection per channel.
    logic [7:0] next_gate;

    genvar ch;
    generate
        for (ch = 0; ch < lowside_switch_pkg::CHANNELS; ch++)
        begin : gen_gate
            if (ch < lowside_switch_pkg::SERIAL_CHANNELS)
            begin : gen_serial
                assign next_gate[ch] = ovLatched ? 1'b0 : modeHigh ? pairSync[ch / 2]
                    : (commandReg[ch] | parallelSync[ch]);
            end
            else
            begin : gen_parallel
                assign next_gate[ch] = ~ovLatched & ~modeHigh & parallelSync[ch];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            gateDrive <= lowside_switch_pkg::GATE_RESET;
        else if (clockEnable)
            gateDrive <= next_gate;
    end

    assign switch_outputs = ~gateDrive;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_ov_gates_off: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && ovLatched |=> gateDrive == 8'h00)
        else $error("Gate active after over-voltage latch.");
    a_output_inverse: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable |=> switch_outputs == ~$past(next_gate))
        else $error("Switch output not inverse of gate.");
    a_so_released: assert property (@(posedge clk) disable iff (!reset_n)
        $past(clockEnable) && $past(clockEnable, 2) && $past(chipSelect_n, 2)
        |-> !serialOutEnable)
        else $error("Serial output driven while deselected.");
    a_so_driven: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2) && $past(clockEnable) && $past(clockEnable, 2)
        && !$past(chipSelect_n, 2) && !$past(modeOverride, 2) |-> serialOutEnable)
        else $error("Serial output not driven while selected.");
    a_command_latch: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && csRise |=> commandReg == $past(shiftReg))
        else $error("Command not latched at end of frame.");
    a_mode_ones: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && csFall && modeHigh |=> serialOut && shiftReg == 8'hff)
        else $error("Status not all ones under mode.");
    a_or_combine: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && !ovLatched && !modeHigh && parallelSync[0]
        |=> gateDrive[0])
        else $error("Parallel input did not turn channel on.");
    a_pair_drive: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && !ovLatched && modeHigh |=> gateDrive[5:4] == {2{$past(pairSync[2])}})
        else $error("Pair pin did not drive its channels.");
    a_msb_first: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && csFall && !modeHigh |=> serialOut == $past(faultStatus[7]))
        else $error("First status bit is not channel seven.");
    a_shift_in: assert property (@(posedge clk) disable iff (!reset_n)
        clockEnable && selected && sclkRise && !csFall |=> shiftReg[0] == $past(siSync[1]))
        else $error("Serial input not sampled on rising edge.");

endmodule

// file: sim/host_serial_model.sv
// Behavioural host that runs serial frames against the switch control block.
module host_serial_model
(
    // Clock.
    input  wire logic clk,
    // Serial link.
    input  wire logic serialLine,
    output logic      serialClock,
    output logic      chipSelect_n,
    output logic      serialIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // The data line has a pull-down, so idle low rather than holding the last bit.
    initial
    begin
        serialClock  = 1'b0;
        chipSelect_n = 1'b1;
        serialIn     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic [15:0] tx, input int bits, output logic [15:0] rx);
        rx = 16'h0000;
        chipSelect_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = bits - 1; i >= 0; i--)
        begin
            serialIn <= tx[i];
            repeat (4) @(posedge clk);
            serialClock <= 1'b1;
            rx = {rx[14:0], serialLine};
            repeat (4) @(posedge clk);
            serialClock <= 1'b0;
        end
        repeat (4) @(posedge clk);
        chipSelect_n <= 1'b1;
        serialIn     <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
endmodule

// file: sim/lowside_switch_serial_control_tb_top.sv
// Self-checking bench for the low-side switch serial control block.
module lowside_switch_serial_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset_n, serialClock, chipSelect_n, serialIn, serialOut;
    logic        serialOutEnable, serialLine, modeOverride, overVoltage, overVoltageClear;
    logic        pair01, pair23, pair45, clockEnable;
    logic [7:0]  parallelPins, outputShorted, outputOpenOrGround;
    logic [7:0]  gateDrive, switch_outputs, commandLatched;
    logic [15:0] rx;
    int          numErrors, nChecks;

    // The line has a pull-up, so a released output reads high.
    assign serialLine = serialOutEnable ? serialOut : 1'b1;

    always #12.5 clk = ~clk;

    lowside_switch_serial_control lowside_switch_serial_control_inst
    (
        .clk(clk), .reset_n(reset_n), .clockEnable(clockEnable),
        .serialClock(serialClock), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEnable(serialOutEnable),
        .parallel_channel_inputs(parallelPins), .pair_input_ch0_ch1(pair01),
        .pair_input_ch2_ch3(pair23), .pair_input_ch4_ch5(pair45),
        .modeOverride(modeOverride), .overVoltage(overVoltage),
        .overVoltageClear(overVoltageClear), .outputShorted(outputShorted),
        .outputOpenOrGround(outputOpenOrGround), .gateDrive(gateDrive),
        .switch_outputs(switch_outputs), .commandLatched(commandLatched)
    );

    host_serial_model host_serial_model_inst
    (
        .clk(clk), .serialLine(serialLine), .serialClock(serialClock),
        .chipSelect_n(chipSelect_n), .serialIn(serialIn)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic run(input logic [15:0] tx, input int bits);
        host_serial_model_inst.frame(tx, bits, rx);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_serial();
        run(16'h003f, 8);
        check("status", rx, 16'h0000);
        check("gates", gateDrive, 8'h3f);
        check("outputs", switch_outputs, 8'hc0);
        check("release", serialOutEnable, 1'b0);
        parallelPins <= 8'hc5;
        run(16'h002a, 8);
        check("orGates", gateDrive, 8'hef);
        check("orOutputs", switch_outputs, 8'h10);
        check("command", commandLatched, 8'h2a);
        parallelPins <= 8'h00;
        repeat (4) @(posedge clk);
    endtask

    // A double frame is the only way to see the echo; single frames return status only.
    task automatic test_echo();
        run(16'h150c, 16);
        check("echo", rx, 16'h002a);
        check("lastByte", gateDrive, 8'h0c);
        check("lastCommand", commandLatched, 8'h0c);
    endtask

    task automatic test_fault();
        outputShorted      <= 8'h04;
        outputOpenOrGround <= 8'h80;
        run(16'h000c, 8);
        check("faults", rx, 16'h0084);
        outputShorted      <= 8'h00;
        outputOpenOrGround <= 8'h00;
    endtask

    task automatic test_mode();
        modeOverride <= 1'b1;
        pair01       <= 1'b1;
        pair45       <= 1'b1;
        parallelPins <= 8'hff;
        repeat (8) @(posedge clk);
        run(16'h0024, 8);
        check("modeStatus", rx, 16'h00ff);
        check("modeGates", gateDrive, 8'h33);
        pair01       <= 1'b0;
        pair23       <= 1'b1;
        repeat (8) @(posedge clk);
        check("pairSwap", gateDrive, 8'h3c);
        modeOverride <= 1'b0;
        parallelPins <= 8'h00;
        repeat (8) @(posedge clk);
        check("modeExit", gateDrive, 8'h24);
    endtask

    task automatic test_overvoltage();
        run(16'h003f, 8);
        overVoltage      <= 1'b1;
        overVoltageClear <= 1'b1;
        @(posedge clk);
        overVoltage      <= 1'b0;
        overVoltageClear <= 1'b0;
        repeat (8) @(posedge clk);
        check("ovGates", gateDrive, 8'h00);
        check("ovOutputs", switch_outputs, 8'hff);
        overVoltageClear <= 1'b1;
        @(posedge clk);
        overVoltageClear <= 1'b0;
        repeat (8) @(posedge clk);
        check("ovCleared", gateDrive, 8'h3f);
    endtask

    task automatic test_freeze();
        clockEnable  <= 1'b0;
        parallelPins <= 8'hc0;
        repeat (8) @(posedge clk);
        check("frozenGates", gateDrive, 8'h3f);
        clockEnable  <= 1'b1;
        repeat (8) @(posedge clk);
        check("thawGates", gateDrive, 8'hff);
        parallelPins <= 8'h00;
        reset_n      <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n      <= 1'b1;
        repeat (4) @(posedge clk);
        check("resetGates", gateDrive, 8'h00);
        check("resetCommand", commandLatched, 8'h00);
        run(16'h0005, 8);
        check("afterReset", rx, 16'h0000);
        check("afterGates", gateDrive, 8'h05);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, reset_n, modeOverride, overVoltage, overVoltageClear} = 5'h00;
        {pair01, pair23, pair45} = 3'h0;
        clockEnable = 1'b1;
        {parallelPins, outputShorted, outputOpenOrGround} = 24'h000000;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("resetOutputs", switch_outputs, 8'hff);
        test_serial();
        test_echo();
        test_fault();
        test_mode();
        test_overvoltage();
        test_freeze();
        stop_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        numErrors++;
        stop_test();
    end
endmodule
